/* tei_inputs.sv */
`timescale 1ns/1ps
`include "tei_cfg.svh"

module tei_inputs #(
    parameter int TMR_W = `TEI_TMR_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ext_irq0_input,
    input wire logic ext_irq1_input,
    input wire logic timer0_count_input,
    input wire logic timer1_count_input,
    input wire logic timer0_gate_select,
    input wire logic timer1_gate_select,
    input wire logic ext_irq0_type_select,
    input wire logic ext_irq1_type_select,
    input wire logic timer0_run,
    input wire logic timer1_run,
    input wire tei_pkg::tei_src_e timer0_src,
    input wire tei_pkg::tei_src_e timer1_src,
    input wire logic ext_irq0_flag_clr,
    input wire logic ext_irq1_flag_clr,
    output logic ext_irq0_flag,
    output logic ext_irq1_flag,
    output logic [TMR_W-1:0] timer0_count,
    output logic [TMR_W-1:0] timer1_count
);
    import tei_pkg::*;

    // Pin vectors: index 0 irq0, 1 irq1, 2 count0, 3 count1
    logic [3:0] pin_in;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] prev_r;
    logic [3:0] fall;
    logic [1:0] type_sel;
    logic [1:0] gate_sel;
    logic [1:0] run_sel;
    logic [1:0] flag_clr;
    logic [1:0] src_cnt;
    logic [1:0] flag_r;
    logic [TMR_W-1:0] cnt_r [2];

    // Counter-mode decode, shared by the tick mux and the checks
    function automatic logic is_counter(input tei_src_e src);
        return src == TEI_SRC_COUNTER;
    endfunction

    assign pin_in = {timer1_count_input, timer0_count_input, ext_irq1_input, ext_irq0_input};
    assign type_sel = {ext_irq1_type_select, ext_irq0_type_select};
    assign gate_sel = {timer1_gate_select, timer0_gate_select};
    assign run_sel = {timer1_run, timer0_run};
    assign flag_clr = {ext_irq1_flag_clr, ext_irq0_flag_clr};
    assign src_cnt = {is_counter(timer1_src), is_counter(timer0_src)};

    // Two-stage synchronisers, idle high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= {4{`TEI_SYNC_RST}};
            sync2_r <= {4{`TEI_SYNC_RST}};
            prev_r <= {4{`TEI_SYNC_RST}};
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // Falling edge: high sample then low sample
    assign fall = prev_r & ~sync2_r;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            logic irq_set;
            logic gate_ok;
            logic tick;

            // Edge or level trigger select
            assign irq_set = type_sel[g] ? fall[g] : ~sync2_r[g];

            // Interrupt pin high permits run when gated
            assign gate_ok = run_sel[g] & (~gate_sel[g] | sync2_r[g]);

            // Counter mode uses count pin edges, else every clock
            assign tick = gate_ok & (src_cnt[g] ? fall[g+2] : 1'b1);

            // Sticky flag, set wins over clear
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    flag_r[g] <= `TEI_FLAG_RST;
                end else if (irq_set) begin
                    flag_r[g] <= 1'b1;
                end else if (flag_clr[g]) begin
                    flag_r[g] <= 1'b0;
                end
            end

            // Timer count
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    cnt_r[g] <= TMR_W'(`TEI_CNT_RST);
                end else if (tick) begin
                    cnt_r[g] <= cnt_r[g] + TMR_W'(1);
                end
            end

            a_edge_flag: assert property (@(posedge clk) disable iff (!nrst)
                (type_sel[g] && prev_r[g] && !sync2_r[g]) |=> flag_r[g])
                else $error("edge did not set flag");
            a_level_flag: assert property (@(posedge clk) disable iff (!nrst)
                (!type_sel[g] && !sync2_r[g]) |=> flag_r[g])
                else $error("low level did not set flag");
            a_gate_hold: assert property (@(posedge clk) disable iff (!nrst)
                (gate_sel[g] && !sync2_r[g]) |=> cnt_r[g] == $past(cnt_r[g]))
                else $error("gated timer advanced");
            a_cnt_edge: assert property (@(posedge clk) disable iff (!nrst)
                (src_cnt[g] && gate_ok && fall[g+2]) |=> cnt_r[g] == $past(cnt_r[g]) + TMR_W'(1))
                else $error("counter missed edge");
            a_cnt_still: assert property (@(posedge clk) disable iff (!nrst)
                (src_cnt[g] && !fall[g+2]) |=> $stable(cnt_r[g]))
                else $error("counter moved without edge");
            a_edge_once: assert property (@(posedge clk) disable iff (!nrst)
                fall[g+2] |=> !fall[g+2])
                else $error("edge seen twice");
            a_flag_keep: assert property (@(posedge clk) disable iff (!nrst)
                (flag_r[g] && !flag_clr[g]) |=> flag_r[g])
                else $error("flag lost");
            a_clr_ok: assert property (@(posedge clk) disable iff (!nrst)
                (flag_clr[g] && !irq_set) |=> !flag_r[g])
                else $error("flag not cleared");
        end
    endgenerate

    // Whole-block checks, written out per channel except the synchroniser and history shifts; the gate hold is for timer 1 only

    // Second synchroniser stage follows the first
    a_sync_shift: assert property (@(posedge clk) disable iff (!nrst)
        sync2_r == $past(sync1_r))
        else $error("synchroniser stage skipped");

    // History stage follows the second stage
    a_hist_shift: assert property (@(posedge clk) disable iff (!nrst)
        prev_r == $past(sync2_r))
        else $error("history stage skipped");

    // Stopped timer 0 holds its count
    a_run_stop0: assert property (@(posedge clk) disable iff (!nrst)
        !run_sel[0] |=> $stable(cnt_r[0]))
        else $error("stopped timer0 advanced");

    // Stopped timer 1 holds its count
    a_run_stop1: assert property (@(posedge clk) disable iff (!nrst)
        !run_sel[1] |=> $stable(cnt_r[1]))
        else $error("stopped timer1 advanced");

    // Timer 0 in timer mode steps once per clock when permitted
    a_timer_tick0: assert property (@(posedge clk) disable iff (!nrst)
        (!src_cnt[0] && run_sel[0] && (!gate_sel[0] || sync2_r[0]))
        |=> cnt_r[0] == $past(cnt_r[0]) + TMR_W'(1))
        else $error("timer0 missed a clock");

    // Timer 1 in timer mode steps once per clock when permitted
    a_timer_tick1: assert property (@(posedge clk) disable iff (!nrst)
        (!src_cnt[1] && run_sel[1] && (!gate_sel[1] || sync2_r[1]))
        |=> cnt_r[1] == $past(cnt_r[1]) + TMR_W'(1))
        else $error("timer1 missed a clock");

    // Low gate pin freezes timer 1
    a_gate_hold1: assert property (@(posedge clk) disable iff (!nrst)
        (gate_sel[1] && !sync2_r[1]) |=> $stable(cnt_r[1]))
        else $error("gated timer1 advanced");

    // Edge mode: a steady low never sets flag 0
    a_edge_no_set0: assert property (@(posedge clk) disable iff (!nrst)
        (type_sel[0] && !fall[0] && !flag_r[0] && !flag_clr[0]) |=> !flag_r[0])
        else $error("flag0 set without edge");

    // Edge mode: a steady low never sets flag 1
    a_edge_no_set1: assert property (@(posedge clk) disable iff (!nrst)
        (type_sel[1] && !fall[1] && !flag_r[1] && !flag_clr[1]) |=> !flag_r[1])
        else $error("flag1 set without edge");

    // Level mode: low pin sets flag 0
    a_level_set0: assert property (@(posedge clk) disable iff (!nrst)
        (!type_sel[0] && !sync2_r[0]) |=> flag_r[0])
        else $error("low level did not set flag0");

    // Level mode: low pin sets flag 1
    a_level_set1: assert property (@(posedge clk) disable iff (!nrst)
        (!type_sel[1] && !sync2_r[1]) |=> flag_r[1])
        else $error("low level did not set flag1");

    // Set beats a clear in the same cycle on flag 0
    a_set_wins0: assert property (@(posedge clk) disable iff (!nrst)
        (flag_clr[0] && !type_sel[0] && !sync2_r[0]) |=> flag_r[0])
        else $error("clear beat set on flag0");

    // Set beats a clear in the same cycle on flag 1
    a_set_wins1: assert property (@(posedge clk) disable iff (!nrst)
        (flag_clr[1] && !type_sel[1] && !sync2_r[1]) |=> flag_r[1])
        else $error("clear beat set on flag1");

    // Timer 0 never moves by more than one
    a_one_tick0: assert property (@(posedge clk) disable iff (!nrst)
        !$stable(cnt_r[0]) |-> cnt_r[0] == $past(cnt_r[0]) + TMR_W'(1))
        else $error("timer0 jumped");

    // Timer 1 never moves by more than one
    a_one_tick1: assert property (@(posedge clk) disable iff (!nrst)
        !$stable(cnt_r[1]) |-> cnt_r[1] == $past(cnt_r[1]) + TMR_W'(1))
        else $error("timer1 jumped");

    // Outputs straight from flip-flops
    assign ext_irq0_flag = flag_r[0];
    assign ext_irq1_flag = flag_r[1];
    assign timer0_count = cnt_r[0];
    assign timer1_count = cnt_r[1];
endmodule

/* tei_cfg.svh */
`ifndef TEI_CFG_SVH
`define TEI_CFG_SVH

// Default timer width
`define TEI_TMR_W 16
// Reset values
`define TEI_CNT_RST 16'h0000
`define TEI_SYNC_RST 1'b1
`define TEI_FLAG_RST 1'b0

`endif

/* tei_pkg.sv */
package tei_pkg;
    // Timer clocking source
    typedef enum logic [0:0] {
        TEI_SRC_TIMER = 1'b0,
        TEI_SRC_COUNTER = 1'b1
    } tei_src_e;
endpackage

/* tei_pins.sv */
`timescale 1ns/1ps
module tei_pins (
    input wire logic clk,
    output logic [3:0] pin
);
    // Pins idle high on their pull-ups
    initial pin = 4'hf;
    // Move one pin just after a falling clock edge
    task automatic put(input int k, input logic v);
        @(negedge clk);
        pin[k] = v;
    endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
    import tei_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] gs = 2'h0;
    logic [1:0] ts = 2'h0;
    logic [1:0] clr = 2'h0;
    logic [1:0] run = 2'h3;
    tei_src_e src0 = TEI_SRC_COUNTER;
    tei_src_e src1 = TEI_SRC_COUNTER;
    logic [1:0] fl;
    logic [3:0] pin;
    logic [15:0] c0;
    logic [15:0] c1;
    int n_mismatch = 0;
    int n_compared = 0;
    // Clock at 250 MHz
    always #2 clk = ~clk;
    tei_pins tei_pins_i (.clk(clk), .pin(pin));
    tei_inputs tei_inputs_i (.clk(clk), .nrst(nrst),
        .ext_irq0_input(pin[0]), .ext_irq1_input(pin[1]),
        .timer0_count_input(pin[2]), .timer1_count_input(pin[3]),
        .timer0_gate_select(gs[0]), .timer1_gate_select(gs[1]),
        .ext_irq0_type_select(ts[0]), .ext_irq1_type_select(ts[1]),
        .timer0_run(run[0]), .timer1_run(run[1]),
        .timer0_src(src0), .timer1_src(src1),
        .ext_irq0_flag_clr(clr[0]), .ext_irq1_flag_clr(clr[1]),
        .ext_irq0_flag(fl[0]), .ext_irq1_flag(fl[1]),
        .timer0_count(c0), .timer1_count(c1));
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Summary and verdict
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Falling edges on a count pin, one cycle per level
    task automatic pulses(input int k, input int n);
        repeat (n) begin
            tei_pins_i.put(k, 1'b0);
            tei_pins_i.put(k, 1'b1);
        end
        repeat (4) @(negedge clk);
    endtask
    // One-cycle flag clear, then settle
    task automatic clear(input int k);
        @(negedge clk) clr[k] = 1'b1;
        @(negedge clk) clr[k] = 1'b0;
        repeat (5) @(negedge clk);
    endtask
    // Edge mode then level mode with the pin held low
    task automatic irq_case(input int k);
        ts[k] = 1'b1;
        tei_pins_i.put(k, 1'b0);
        repeat (5) @(negedge clk);
        chk("edge flag", 16'h1, {15'h0, fl[k]});
        clear(k);
        chk("edge flag low pin", 16'h0, {15'h0, fl[k]});
        ts[k] = 1'b0;
        repeat (5) @(negedge clk);
        chk("level flag", 16'h1, {15'h0, fl[k]});
        clear(k);
        chk("level flag after clear", 16'h1, {15'h0, fl[k]});
        tei_pins_i.put(k, 1'b1);
        repeat (4) @(negedge clk);
        clear(k);
        chk("flag idle", 16'h0, {15'h0, fl[k]});
    endtask
    // Timer mode: held while stopped, one step per clock while running
    task automatic timer_case(input int k);
        logic [15:0] base;
        @(negedge clk);
        run[k] = 1'b0;
        if (k == 0) src0 = TEI_SRC_TIMER;
        else src1 = TEI_SRC_TIMER;
        base = (k == 0) ? c0 : c1;
        pulses(k + 2, 2);
        chk("stopped count", base, (k == 0) ? c0 : c1);
        run[k] = 1'b1;
        repeat (5) @(negedge clk);
        run[k] = 1'b0;
        chk("timer count", base + 16'h5, (k == 0) ? c0 : c1);
        if (k == 0) src0 = TEI_SRC_COUNTER;
        else src1 = TEI_SRC_COUNTER;
        @(negedge clk);
        run[k] = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    // Counting, gating, then both interrupt lines
    initial begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        pulses(2, 3);
        pulses(3, 3);
        chk("count0", 16'h3, c0);
        chk("count1", 16'h3, c1);
        gs = 2'h3;
        tei_pins_i.put(0, 1'b0);
        tei_pins_i.put(1, 1'b0);
        pulses(2, 2);
        pulses(3, 2);
        chk("gated count0", 16'h3, c0);
        chk("gated count1", 16'h3, c1);
        tei_pins_i.put(0, 1'b1);
        tei_pins_i.put(1, 1'b1);
        pulses(2, 1);
        pulses(3, 1);
        chk("open count0", 16'h4, c0);
        chk("open count1", 16'h4, c1);
        clear(0);
        clear(1);
        irq_case(0);
        irq_case(1);
        timer_case(0);
        timer_case(1);
        end_of_test;
    end
endmodule
